// ---- rtl/ext_bus_ctl.v ----
// Purpose: DRAM wait-state control, write data buffer and pin function control
// Assumes: one 10 MHz clock; wait pin sampled at the rising edge ending the first column or a wait state, once programmed waits are spent
// Notes: wait count per area is 2 bits: area n uses count_l/h bits [2n+1:2n]
`include "ext_bus_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ctl #(
    parameter N_AREA = 8
) (
    input wire i_clk_sys,
    input wire i_rst,
    // AXI4-Lite slave
    input wire [11:0] i_awaddr,
    input wire i_awvalid,
    output wire o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output wire o_wready,
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    input wire [11:0] i_araddr,
    input wire i_arvalid,
    output wire o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready,
    // DRAM access request
    input wire i_acc_start,
    input wire [2:0] i_acc_area,
    input wire i_dram_space,
    output reg o_col_first,
    output reg o_col_wait,
    output reg o_col_second,
    output wire o_acc_done,
    // Wait input pins (active low), two alternatives
    input wire i_wait_pin_a_n,
    input wire i_wait_pin_b_n,
    // Write buffer
    input wire i_ext_wr,
    input wire i_int_req,
    output wire o_int_go,
    // Pin control
    input wire i_breq_out,
    output wire o_breq_pin_a,
    output wire o_breq_pin_b,
    input wire i_as,
    output wire o_as_oe,
    output wire o_as,
    output wire o_cs_group_a_oe,
    output wire o_cs_group_b_oe,
    input wire [2:0] i_op_mode,
    input wire [7:0] i_port_d_out,
    output wire [7:0] o_port_d_oe,
    output wire o_port_d_is_bus
);

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    reg [7:0] port_function_control_two_ff;
    reg [N_AREA-1:0] area_wait_enable_ff;
    reg [7:0] wait_count_high_ff;
    reg [7:0] wait_count_low_ff;
    reg [7:0] bus_control_high_ff;
    reg [7:0] bus_control_low_ff;
    reg [7:0] port_d_direction_ff;
    reg aw_held_ff;
    reg w_held_ff;
    reg [11:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;

    wire wait_pin_enable = bus_control_high_ff[`BIT_WAIT_PIN_EN];
    wire write_buffer_enable = bus_control_low_ff[`BIT_WBUF_EN];

    assign o_awready = !aw_held_ff && !o_bvalid;
    assign o_wready = !w_held_ff && !o_bvalid;
    assign o_arready = !o_rvalid;

    wire aw_fire = i_awvalid && o_awready;
    wire w_fire = i_wvalid && o_wready;
    wire aw_have = aw_held_ff || aw_fire;
    wire w_have = w_held_ff || w_fire;
    wire [11:0] wr_addr = aw_held_ff ? awaddr_ff : i_awaddr;
    wire [31:0] wr_data = w_held_ff ? wdata_ff : i_wdata;
    wire [3:0] wr_strb = w_held_ff ? wstrb_ff : i_wstrb;
    wire do_wr = aw_have && w_have;
    wire wr_lane0 = do_wr && wr_strb[0];

    function known_addr;
        input [11:0] a;
        begin
            case (a)
                `OFF_PFC2, `OFF_AREA_WAIT, `OFF_WAIT_CNT_H, `OFF_WAIT_CNT_L,
                `OFF_BUS_CTL_H, `OFF_BUS_CTL_L, `OFF_PORT_D_DIR, `OFF_STATUS:
                    known_addr = 1'b1;
                default: known_addr = 1'b0;
            endcase
        end
    endfunction

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            port_function_control_two_ff <= `RST_PFC2; // [R7]
            area_wait_enable_ff <= {N_AREA{1'b0}};
            wait_count_high_ff <= 8'hff;
            wait_count_low_ff <= 8'hff;
            bus_control_high_ff <= 8'h00;
            bus_control_low_ff <= 8'h00;
            port_d_direction_ff <= 8'h00;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= 2'b00;
        end else begin
            if (aw_fire && !w_have) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= i_awaddr;
            end
            if (w_fire && !aw_have) begin
                w_held_ff <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (do_wr) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= known_addr(wr_addr) ? 2'b00 : 2'b11;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
            if (wr_lane0) begin
                case (wr_addr)
                    // Read-only low bits stay zero [R11]
                    `OFF_PFC2: port_function_control_two_ff <= wr_data[7:0] & `PFC2_WMASK;
                    `OFF_AREA_WAIT: area_wait_enable_ff <= wr_data[N_AREA-1:0];
                    `OFF_WAIT_CNT_H: wait_count_high_ff <= wr_data[7:0];
                    `OFF_WAIT_CNT_L: wait_count_low_ff <= wr_data[7:0];
                    `OFF_BUS_CTL_H: bus_control_high_ff <= wr_data[7:0];
                    `OFF_BUS_CTL_L: bus_control_low_ff <= wr_data[7:0];
                    `OFF_PORT_D_DIR: port_d_direction_ff <= wr_data[7:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // DRAM wait control
    // ----------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_COL1 = 2'd1;
    localparam ST_WAIT = 2'd2;
    localparam ST_COL2 = 2'd3;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [1:0] prog_left_ff;
    reg [1:0] nxt_prog_left;
    reg [2:0] area_ff;

    wire [15:0] wait_counts = {wait_count_high_ff, wait_count_low_ff};
    wire [1:0] area_count = wait_counts[{i_acc_area, 1'b0} +: 2];
    wire area_prog = i_dram_space && area_wait_enable_ff[i_acc_area]; // [R1]
    // Pin select picks which physical pin is the wait input [R12]
    wire wait_low = port_function_control_two_ff[`BIT_WAIT_PS] ?
                    !i_wait_pin_b_n : !i_wait_pin_a_n;
    // Pin honoured whatever the area enable says [R2]
    wire pin_hold = wait_pin_enable && wait_low;

    always @* begin
        nxt_state = state_ff;
        nxt_prog_left = prog_left_ff;
        case (state_ff)
            ST_IDLE: begin
                if (i_acc_start) begin
                    nxt_state = ST_COL1;
                    nxt_prog_left = area_prog ? area_count : 2'd0; // [R1]
                end
            end
            ST_COL1: begin
                // Programmed waits first, then pin waits [R3] [R4]
                if (prog_left_ff != 2'd0)
                    nxt_state = ST_WAIT;
                else if (pin_hold)
                    nxt_state = ST_WAIT;
                else
                    nxt_state = ST_COL2; // [R18]
            end
            ST_WAIT: begin
                if (prog_left_ff != 2'd0)
                    nxt_prog_left = prog_left_ff - 2'd1;
                if (prog_left_ff > 2'd1)
                    nxt_state = ST_WAIT;
                else if (pin_hold)
                    nxt_state = ST_WAIT; // [R4]
                else
                    nxt_state = ST_COL2; // [R17]
            end
            ST_COL2: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
            prog_left_ff <= 2'd0;
            area_ff <= 3'd0;
            o_col_first <= 1'b0;
            o_col_wait <= 1'b0;
            o_col_second <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            prog_left_ff <= nxt_prog_left;
            if (state_ff == ST_IDLE && i_acc_start)
                area_ff <= i_acc_area;
            o_col_first <= (nxt_state == ST_COL1);
            o_col_wait <= (nxt_state == ST_WAIT);
            o_col_second <= (nxt_state == ST_COL2);
        end
    end

    assign o_acc_done = (state_ff == ST_COL2);

    // ----------------------------------------
    // Write data buffer
    // ----------------------------------------
    reg ext_wr_prev_ff;

    always @(posedge i_clk_sys) begin
        if (i_rst)
            ext_wr_prev_ff <= 1'b0;
        else
            ext_wr_prev_ff <= i_ext_wr;
    end

    // Without the buffer an internal access waits for the write to end [R5]
    // With it, only the write's first state blocks the internal side [R6]
    assign o_int_go = i_int_req &&
                      (!i_ext_wr || (write_buffer_enable && ext_wr_prev_ff));

    // ----------------------------------------
    // Pin function control
    // ----------------------------------------
    wire breq_sel = port_function_control_two_ff[`BIT_BREQ_PS];
    assign o_breq_pin_a = !breq_sel && i_breq_out; // [R13]
    assign o_breq_pin_b = breq_sel && i_breq_out; // [R13]
    assign o_as_oe = !port_function_control_two_ff[`BIT_AS_DIS]; // [R14]
    assign o_as = i_as;
    // Direction bits should be cleared by software before toggling these [R10]
    assign o_cs_group_a_oe = port_function_control_two_ff[`BIT_CS_A]; // [R8]
    assign o_cs_group_b_oe = port_function_control_two_ff[`BIT_CS_B]; // [R9]

    assign o_port_d_is_bus = (i_op_mode >= `MODE_DATA_LO) &&
                             (i_op_mode <= `MODE_DATA_HI); // [R15]
    // Bus mode leaves the data direction to the bus cycle; i_port_d_out bit 0 only feeds bit 7 of the status read
    assign o_port_d_oe = (i_op_mode == `MODE_SINGLE) ? port_d_direction_ff : 8'h00; // [R16]

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= 2'b00;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp <= known_addr(i_araddr) ? 2'b00 : 2'b11;
            case (i_araddr)
                `OFF_PFC2: o_rdata <= {24'h0, port_function_control_two_ff};
                `OFF_AREA_WAIT: o_rdata <= {{(32-N_AREA){1'b0}}, area_wait_enable_ff};
                `OFF_WAIT_CNT_H: o_rdata <= {24'h0, wait_count_high_ff};
                `OFF_WAIT_CNT_L: o_rdata <= {24'h0, wait_count_low_ff};
                `OFF_BUS_CTL_H: o_rdata <= {24'h0, bus_control_high_ff};
                `OFF_BUS_CTL_L: o_rdata <= {24'h0, bus_control_low_ff};
                `OFF_PORT_D_DIR: o_rdata <= {24'h0, port_d_direction_ff};
                `OFF_STATUS: o_rdata <= {24'h0, i_port_d_out[0], area_ff,
                                         prog_left_ff, state_ff};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

endmodule // ext_bus_ctl
`default_nettype wire

// ---- rtl/ext_bus_defs.vh ----
// Purpose: constants for the external bus wait and pin control block
// Assumes: AXI4-Lite register bus, one word per register
// Notes: offsets are byte addresses
// Contract
// R1: Area wait enable inserts 0-3 programmed waits
// R2: Wait pin enable samples pin regardless
// R3: Programmed waits come before pin waits
// R4: Low wait pin adds waits until high
// R5: Write buffer only with buffer enable set
// R6: First state external only, then concurrent
// R7: Port function register resets to 0x30
// R8: Bit 5 enables chip selects 1,6,7
// R9: Bit 4 enables chip selects 2-5
// R10: Software clears direction bits before changing
// R11: Bits 2..0 read as zero
// R12: Bit 7 selects wait input pin
// R13: Bit 6 selects bus request pin
// R14: Bit 3 disables address strobe output
// R15: Modes 4-6 make port D data bus
// R16: Mode 7 port D follows direction
// R17: After waits go to second column
// R18: No enables means no wait states
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH
`define OFF_PFC2 12'h000
`define OFF_AREA_WAIT 12'h004
`define OFF_WAIT_CNT_H 12'h008
`define OFF_WAIT_CNT_L 12'h00c
`define OFF_BUS_CTL_H 12'h010
`define OFF_BUS_CTL_L 12'h014
`define OFF_PORT_D_DIR 12'h018
`define OFF_STATUS 12'h01c
`define RST_PFC2 8'h30
`define PFC2_WMASK 8'hf8
`define BIT_WAIT_PS 7
`define BIT_BREQ_PS 6
`define BIT_CS_A 5
`define BIT_CS_B 4
`define BIT_AS_DIS 3
`define BIT_WAIT_PIN_EN 0
`define BIT_WBUF_EN 0
`define MODE_DATA_LO 3'h4
`define MODE_DATA_HI 3'h6
`define MODE_SINGLE 3'h7
`endif

// ---- verif/ext_bus_ctl_assertions.sv ----
// Purpose: concurrent checks on the wait, buffer and port D outputs
// Assumes: bound to ext_bus_ctl, one clock, sync reset
// Notes: register contents are not visible here
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ctl_chk (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_acc_start,
    input wire logic o_col_first,
    input wire logic o_col_wait,
    input wire logic o_col_second,
    input wire logic o_acc_done,
    input wire logic i_ext_wr,
    input wire logic i_int_req,
    input wire logic o_int_go,
    input wire logic [2:0] i_op_mode,
    input wire logic o_port_d_is_bus,
    input wire logic [7:0] o_port_d_oe
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire idle = !(o_col_first || o_col_wait || o_col_second);
    sequence s_start;
        idle && i_acc_start;
    endsequence
    sequence s_col1;
        o_col_first ##1 (o_col_wait || o_col_second);
    endsequence
    a_start_first: assert property (s_start |=> s_col1)
        else $error("first column missing after start");
    a_second_one: assert property (o_col_second |=> idle)
        else $error("second column not followed by idle");
    a_state_onehot: assert property ($onehot0({o_col_first, o_col_wait, o_col_second}))
        else $error("column states overlap");
    a_done_second: assert property (o_acc_done == o_col_second)
        else $error("done differs from second column");
    a_buf_first: assert property ($rose(i_ext_wr) && i_int_req |-> !o_int_go)
        else $error("internal access in first write state");
    a_int_free: assert property (!i_ext_wr && i_int_req |-> o_int_go)
        else $error("internal access blocked without write");
    a_mode_bus: assert property (o_port_d_is_bus == (i_op_mode >= 3'h4 && i_op_mode <= 3'h6))
        else $error("port D bus function wrong for mode");
    a_mode_oe: assert property (i_op_mode != 3'h7 |-> o_port_d_oe == 8'h00)
        else $error("port D driven outside mode 7");
endmodule // ext_bus_ctl_chk
bind ext_bus_ctl ext_bus_ctl_chk ext_bus_ctl_chk_i (.i_clk_sys, .i_rst, .i_acc_start,
    .o_col_first, .o_col_wait, .o_col_second, .o_acc_done, .i_ext_wr, .i_int_req,
    .o_int_go, .i_op_mode, .o_port_d_is_bus, .o_port_d_oe);
`default_nettype wire

// ---- verif/ext_wait_model.sv ----
// Purpose: external party holding the wait pin low for a set count
// Assumes: pins are pulled up when not driven low
// Notes: unselected pin is held low so a wrong pin choice hangs the access
`timescale 1ns/1ps
`default_nettype none
module ext_wait_model (
    input wire logic i_clk_sys,
    input wire logic i_busy,
    input wire logic i_wait,
    input wire logic i_sel,
    input wire logic [2:0] i_waits,
    output logic o_pin_a_n,
    output logic o_pin_b_n
);
    logic [2:0] seen_ff;
    logic low;
    always @(posedge i_clk_sys) seen_ff <= i_busy ? seen_ff + {2'h0, i_wait} : 3'h0;
    // Low while more wait states are still wanted after this one
    assign low = i_busy && ((seen_ff + {2'h0, i_wait}) < i_waits);
    assign o_pin_a_n = i_sel ? 1'b0 : !low;
    assign o_pin_b_n = i_sel ? !low : 1'b0;
endmodule // ext_wait_model
`default_nettype wire

// ---- verif/ext_bus_ctl_tb_top.sv ----
// Purpose: register, wait state, buffer and port D tests
// Assumes: AXI4-Lite master tasks, 10 MHz clock
// Notes: expected values are literals written in the checks, not the register map constants
`include "ext_bus_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ctl_tb_top;
    logic i_clk_sys, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_acc_start;
    logic i_dram_space, i_ext_wr, i_int_req, i_breq_out, i_as, m_sel;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, rdat;
    logic [3:0] i_wstrb;
    logic [2:0] i_acc_area, i_op_mode, m_waits;
    logic [7:0] i_port_d_out, o_port_d_oe;
    logic [1:0] o_bresp, o_rresp, resp;
    logic [31:0] o_rdata;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_col_first, o_col_wait;
    logic o_col_second, o_acc_done, o_int_go, o_breq_pin_a, o_breq_pin_b, o_as_oe, o_as;
    logic o_cs_group_a_oe, o_cs_group_b_oe, o_port_d_is_bus, i_wait_pin_a_n, i_wait_pin_b_n;
    int fails = 0;
    int n_checks = 0;
    ext_bus_ctl ext_bus_ctl_i (.i_clk_sys, .i_rst, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_acc_start,
        .i_acc_area, .i_dram_space, .o_col_first, .o_col_wait, .o_col_second, .o_acc_done,
        .i_wait_pin_a_n, .i_wait_pin_b_n, .i_ext_wr, .i_int_req, .o_int_go, .i_breq_out,
        .o_breq_pin_a, .o_breq_pin_b, .i_as, .o_as_oe, .o_as, .o_cs_group_a_oe,
        .o_cs_group_b_oe, .i_op_mode, .i_port_d_out, .o_port_d_oe, .o_port_d_is_bus);
    ext_wait_model ext_wait_model_i (.i_clk_sys, .i_busy(o_col_first || o_col_wait),
        .i_wait(o_col_wait), .i_sel(m_sel), .i_waits(m_waits), .o_pin_a_n(i_wait_pin_a_n),
        .o_pin_b_n(i_wait_pin_b_n));
    initial begin
        i_clk_sys = 0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        for (int t = 0; t < 40; t++) begin
            @(posedge i_clk_sys);
            if (o_awready) i_awvalid <= 0;
            if (o_wready) i_wvalid <= 0;
            if (o_bvalid) break;
        end
        chk("b_answer", 1, o_bvalid);
        resp = o_bresp;
        i_bready <= 0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge i_clk_sys);
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= 1;
        for (int t = 0; t < 40; t++) begin
            @(posedge i_clk_sys);
            if (o_arready) i_arvalid <= 0;
            if (o_rvalid) break;
        end
        chk("r_answer", 1, o_rvalid);
        rdat = o_rdata;
        resp = o_rresp;
        i_rready <= 0;
    endtask
    // DRAM access: count wait states between the column states
    task automatic acc(input logic [2:0] ar, input int e);
        int n;
        @(posedge i_clk_sys);
        i_acc_area <= ar;
        i_dram_space <= 1;
        i_acc_start <= 1;
        @(posedge i_clk_sys);
        i_acc_start <= 0;
        @(posedge i_clk_sys);
        chk("col_first", 1, o_col_first);
        n = 0;
        for (int t = 0; t < 20 && !o_col_second; t++) begin
            @(posedge i_clk_sys);
            n += o_col_wait;
        end
        chk("waits", e, n);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(100 * 5000);
        fails++;
        tally_and_finish;
    end
    initial begin
        int p;
        i_rst = 1;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_acc_start, i_dram_space} = 0;
        {i_ext_wr, i_int_req, i_as, m_sel, i_awaddr, i_araddr, i_wdata, i_acc_area} = 0;
        {i_op_mode, i_port_d_out, m_waits} = 0;
        i_breq_out = 1;
        i_wstrb = 4'hf;
        repeat (8) @(posedge i_clk_sys);
        i_rst <= 0;
        rd(`OFF_PFC2);
        chk("pfc_reset", 32'h30, rdat);
        chk("oe_reset", 3'h7, {o_cs_group_a_oe, o_cs_group_b_oe, o_as_oe});
        wr(`OFF_PORT_D_DIR, 0);
        wr(`OFF_PFC2, 32'hff);
        rd(`OFF_PFC2);
        chk("pfc_ro", 32'hf8, rdat);
        chk("as_oe", 0, o_as_oe);
        chk("breq_b", 1, o_breq_pin_b);
        wr(`OFF_PFC2, 32'h20);
        chk("cs_a", 2'h2, {o_cs_group_a_oe, o_cs_group_b_oe});
        chk("breq_a", 1, o_breq_pin_a);
        wr(`OFF_PFC2, 32'h10);
        chk("cs_b", 2'h1, {o_cs_group_a_oe, o_cs_group_b_oe});
        rd(12'h100);
        chk("rresp", 3, resp);
        wr(`OFF_AREA_WAIT, 32'h21);
        for (p = 0; p < 4; p++) begin
            wr(`OFF_WAIT_CNT_L, p);
            acc(0, p);
        end
        wr(`OFF_WAIT_CNT_H, 32'h0c);
        acc(5, 3);
        wr(`OFF_AREA_WAIT, 0);
        acc(0, 0);
        wr(`OFF_BUS_CTL_H, 1);
        m_waits <= 2;
        acc(0, 2);
        wr(`OFF_AREA_WAIT, 1);
        wr(`OFF_WAIT_CNT_L, 2);
        m_waits <= 1;
        acc(0, 2);
        wr(`OFF_WAIT_CNT_L, 1);
        wr(`OFF_PFC2, 32'hb0);
        m_sel <= 1;
        m_waits <= 3;
        acc(0, 3);
        wr(`OFF_BUS_CTL_H, 0);
        acc(0, 1);
        for (p = 1; p >= 0; p--) begin
            wr(`OFF_BUS_CTL_L, p);
            i_ext_wr <= 1;
            i_int_req <= 1;
            // First state of the write: the previous-cycle flag is still low here
            @(posedge i_clk_sys);
            chk("go_first", 0, o_int_go);
            @(posedge i_clk_sys);
            chk("go_next", p, o_int_go);
            i_ext_wr <= 0;
            @(posedge i_clk_sys);
            chk("go_free", 1, o_int_go);
            i_int_req <= 0;
        end
        wr(`OFF_PORT_D_DIR, 32'ha5);
        for (p = 0; p < 8; p++) begin
            i_op_mode <= p[2:0];
            @(posedge i_clk_sys);
            @(posedge i_clk_sys);
            chk("d_bus", p >= 4 && p <= 6, o_port_d_is_bus);
            chk("d_oe", p == 7 ? 32'ha5 : 32'h0, o_port_d_oe);
        end
        tally_and_finish;
    end
endmodule // ext_bus_ctl_tb_top
`default_nettype wire
